/* File: fieldbus_slave_diag_status.sv */
// Builds the slave diagnostics frame and the diagnostics interrupt.
// Assumes all inputs synchronous to clk; reads come from the link side.
`include "diag_frame_params.svh"
module fieldbus_slave_diag_status
    import diag_frame_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   dpv1_mode,
    input  wire logic   diag_int_enable,
    input  wire event_t diag_events,
    input  wire logic   starting_up,
    input  wire logic   cfg_mismatch,
    input  wire logic   unsupported_req,
    input  wire logic   type_mismatch,
    input  wire logic   foreign_master,
    input  wire len_t   req_len,
    input  wire logic   ext_wr_en,
    input  wire addr_t  ext_wr_addr,
    input  wire byte_t  ext_wr_data,
    input  wire logic   rd_req,
    input  wire addr_t  rd_addr,
    input  wire logic   int_ack,
    output logic        rd_valid,
    output byte_t       rd_data,
    output len_t        frame_len,
    output byte_t       station_state_byte_first,
    output logic        diag_int,
    output logic        int_incoming
);
    frame_mem_if        mem_bus ();

    event_t  diag_prev_reg;
    byte_t   station_state_byte_first_reg;
    byte_t   station_state_byte_first_next;
    byte_t   status2_reg;
    len_t    frame_len_reg;
    logic    diag_int_reg;
    logic    int_incoming_reg;
    logic    rd_p1_reg;
    addr_t   rd_addr_p1_reg;
    logic    rd_valid_reg;
    byte_t   rd_data_reg;
    logic    diag_change;
    logic    int_set;

    frame_mem u_mem (
        .clk    (clk),
        .resetn (resetn),
        .port   (mem_bus)
    );

    // ****************************************************************
    // Station status bytes
    // ****************************************************************
    // Bits 0 and 5 belong to the master's copy, never set here
    always_comb begin
        station_state_byte_first_next = `STATUS_RESET;
        station_state_byte_first_next[`S1_NO_REACH]   = 1'b0;
        station_state_byte_first_next[`S1_NOT_READY]  = starting_up;
        station_state_byte_first_next[`S1_CFG_FAULT]  = cfg_mismatch;
        station_state_byte_first_next[`S1_EXT_DIAG]   = |diag_events;
        station_state_byte_first_next[`S1_NOT_SUPP]   =
            unsupported_req;
        station_state_byte_first_next[`S1_BAD_RESP]   = 1'b0;
        station_state_byte_first_next[`S1_TYPE_FAULT] = type_mismatch;
        station_state_byte_first_next[`S1_OTHER_MASTER] =
            foreign_master;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            station_state_byte_first_reg <= `STATUS_RESET;
            status2_reg                  <= `STATUS_RESET;
        end else begin
            station_state_byte_first_reg <= station_state_byte_first_next;
            status2_reg                  <= `STATUS_RESET;
            status2_reg[`S2_PRESENT]     <= 1'b1;
        end
    end

    // ****************************************************************
    // Frame length cap
    // ****************************************************************
    // A longer request is clipped rather than refused
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frame_len_reg <= `FRAME_MAX_LEN;
        end else if (req_len > `FRAME_MAX_LEN) begin
            frame_len_reg <= `FRAME_MAX_LEN;
        end else begin
            frame_len_reg <= req_len;
        end
    end

    // ****************************************************************
    // Diagnostics interrupt
    // ****************************************************************
    assign diag_change = (diag_events != diag_prev_reg);
    // Only one interrupt kind exists; DPV0 operation mutes it
    assign int_set = diag_change && diag_int_enable
                     && dpv1_mode;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            diag_prev_reg <= '0;
        end else begin
            diag_prev_reg <= diag_events;
        end
    end

    // A new event in the acknowledge cycle keeps the request standing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            diag_int_reg     <= 1'b0;
            int_incoming_reg <= 1'b0;
        end else if (int_set) begin
            diag_int_reg     <= 1'b1;
            int_incoming_reg <= |(diag_events & ~diag_prev_reg);
        end else if (int_ack) begin
            diag_int_reg     <= 1'b0;
        end
    end

    // ****************************************************************
    // Frame store and read path
    // ****************************************************************
    // Status bytes are built here, so writes to them are dropped
    assign mem_bus.wr_en   = ext_wr_en && (ext_wr_addr > `ADDR_STATUS3);
    assign mem_bus.wr_addr = ext_wr_addr;
    assign mem_bus.wr_data = ext_wr_data;
    assign mem_bus.rd_addr = rd_addr;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_p1_reg      <= 1'b0;
            rd_addr_p1_reg <= `ADDR_STATUS1;
        end else begin
            rd_p1_reg      <= rd_req;
            rd_addr_p1_reg <= rd_addr;
        end
    end

    // Bytes at or past the frame length read as zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= `STATUS_RESET;
        end else begin
            rd_valid_reg <= rd_p1_reg;
            if (!rd_p1_reg) begin
                rd_data_reg <= `STATUS_RESET;
            end else if ({1'b0, rd_addr_p1_reg} >= frame_len_reg) begin
                rd_data_reg <= `STATUS_RESET;
            end else begin
                case (rd_addr_p1_reg)
                    `ADDR_STATUS1: rd_data_reg <= station_state_byte_first_reg;
                    `ADDR_STATUS2: rd_data_reg <= status2_reg;
                    `ADDR_STATUS3: rd_data_reg <= `STATUS_RESET;
                    default:       rd_data_reg <= mem_bus.rd_data;
                endcase
            end
        end
    end

    assign rd_valid                 = rd_valid_reg;
    assign rd_data                  = rd_data_reg;
    assign frame_len                = frame_len_reg;
    assign station_state_byte_first = station_state_byte_first_reg;
    assign diag_int                 = diag_int_reg;
    assign int_incoming             = int_incoming_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    len_cap_a: assert property (frame_len_reg <= `FRAME_MAX_LEN)
        else $error("frame length above cap");

    dpv0_quiet_a: assert property (
        $rose(diag_int_reg) |-> $past(dpv1_mode))
        else $error("interrupt raised outside extended mode");

    int_on_change_a: assert property (
        (dpv1_mode && diag_int_enable && diag_events != diag_prev_reg)
        |=> diag_int_reg)
        else $error("event change gave no interrupt");

    int_needs_enable_a: assert property (
        $rose(diag_int_reg) |-> $past(diag_int_enable)
                                && $past(diag_events != diag_prev_reg))
        else $error("interrupt without enabled event");

    startup_read_a: assert property (
        (rd_req && rd_addr == `ADDR_STATUS1 && req_len != 6'h00)
        |-> ##2 rd_valid && rd_data[`S1_NOT_READY] == $past(starting_up, 2))
        else $error("status byte read lost startup state");

    group_flag_a: assert property (
        (diag_events == '0) |=> !station_state_byte_first_reg[`S1_EXT_DIAG])
        else $error("group flag set with no diagnostics");

    master_bits_a: assert property (
        !station_state_byte_first_reg[`S1_NO_REACH]
        && !station_state_byte_first_reg[`S1_BAD_RESP])
        else $error("master-owned bits driven by slave");

    present_bit_a: assert property (
        (rd_req && rd_addr == `ADDR_STATUS2 && req_len > 6'h01)
        |-> ##2 rd_data[`S2_PRESENT])
        else $error("presence bit read as zero");

    // Back to back reads are legal, so valid mirrors the request stream
    read_latency_a: assert property (
        $past(resetn) && $past(resetn, 2) |-> rd_valid == $past(rd_req, 2))
        else $error("read answer not after two cycles");

    status_follow_a: assert property (
        $past(resetn) |->
        station_state_byte_first_reg[`S1_CFG_FAULT] == $past(cfg_mismatch)
        && station_state_byte_first_reg[`S1_NOT_SUPP] == $past(unsupported_req)
        && station_state_byte_first_reg[`S1_TYPE_FAULT] == $past(type_mismatch)
        && station_state_byte_first_reg[`S1_OTHER_MASTER]
           == $past(foreign_master))
        else $error("status bits do not follow conditions");

    ack_clear_a: assert property (
        (int_ack && !int_set) |=> !diag_int_reg)
        else $error("acknowledge left interrupt pending");

    int_cov_c:   cover property ($rose(diag_int_reg));
    rd0_cov_c:   cover property (rd_req && rd_addr == `ADDR_STATUS1);
    clip_cov_c:  cover property (req_len > `FRAME_MAX_LEN);
    ack_cov_c:   cover property (diag_int_reg && int_ack && int_set);
endmodule

/* File: diag_frame_params.svh */
// Constants of the slave diagnostics frame builder.
// Assumes one clock domain and inclusion by package and design files.
// Function
// - Diagnostics frame never exceeds 32 bytes
// - Diagnostics interrupt is the only interrupt
// - No interrupts with DPV0 master or mode
// - Enabled interrupt on incoming or outgoing event
// - Status byte 0 bit 1: starting up
// - Bit 2: configuration mismatch from master
// - Bit 3: group flag, any pending diagnostics
// - Bit 4: requested function not supported
// - Bit 6: slave type mismatch
// - Bit 7: parameterized by another master
// - Status byte 1 bit 2 always one
`ifndef DIAG_FRAME_PARAMS_SVH
`define DIAG_FRAME_PARAMS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define FRAME_MAX_LEN     6'h20
`define FRAME_DEPTH       32
`define ADDR_STATUS1      5'h00
`define ADDR_STATUS2      5'h01
`define ADDR_STATUS3      5'h02
`define STATUS_RESET      8'h00
`define EVENT_WIDTH       8
`define RD_LATENCY        2

// ****************************************************************
// Station status bit positions
// ****************************************************************
`define S1_NO_REACH       0
`define S1_NOT_READY      1
`define S1_CFG_FAULT      2
`define S1_EXT_DIAG       3
`define S1_NOT_SUPP       4
`define S1_BAD_RESP       5
`define S1_TYPE_FAULT     6
`define S1_OTHER_MASTER   7
`define S2_PRESENT        2

`endif

/* File: diag_frame_pkg.sv */
// Types shared by the diagnostics frame builder.
// Assumes the constants header sits in the same folder.
package diag_frame_pkg;
    `include "diag_frame_params.svh"
    typedef logic [7:0]                 byte_t;
    typedef logic [4:0]                 addr_t;
    typedef logic [5:0]                 len_t;
    typedef logic [`EVENT_WIDTH-1:0]    event_t;
endpackage

/* File: frame_mem_if.sv */
// Carrier between the frame builder and its byte store.
// Assumes both ends share one clock.
interface frame_mem_if;
    import diag_frame_pkg::*;
    logic   wr_en;
    addr_t  wr_addr;
    byte_t  wr_data;
    addr_t  rd_addr;
    byte_t  rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

/* File: frame_mem.sv */
// Byte store for the diagnostics frame, registered read data.
// Assumes a synchronous active-low reset and one clock.
`include "diag_frame_params.svh"
module frame_mem
    import diag_frame_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   resetn,
    frame_mem_if.mem    port
);
    byte_t  mem_reg [`FRAME_DEPTH];
    byte_t  rd_data_reg;

    // ****************************************************************
    // Storage
    // ****************************************************************
    // No reset on the array keeps it a plain memory
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_reg[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data_reg <= `STATUS_RESET;
        end else begin
            rd_data_reg <= mem_reg[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_reg;
endmodule

/* File: dp_master_model.sv */
// Master side model: fetches frame bytes over the slave read port.
// Assumes the slave answers two cycles after a taken request.
module dp_master_model
    import diag_frame_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rd_valid,
    input  wire byte_t rd_data,
    output logic       rd_req,
    output addr_t      rd_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Read cycle
    // ****
    initial begin
        rd_req  = 1'b0;
        rd_addr = 5'h1f;
    end
    // Idle address is inverted so a stale index is never reused
    task automatic read(input addr_t a, output byte_t d);
        int n;
        d = 8'h01; // Silent slave reads as unreachable
        @(posedge clk);
        rd_req  <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_req  <= 1'b0;
        rd_addr <= ~a;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (rd_valid === 1'b1) begin
                // Unreadable answer flagged in the copy
                d = (^rd_data === 1'bx) ? 8'h20 : rd_data;
                break;
            end
        end
    endtask
endmodule

/* File: fieldbus_slave_diag_status_tb.sv */
// Self-checking bench of the diagnostics frame builder.
// Assumes the package, the design and the master model are compiled.
module fieldbus_slave_diag_status_tb
    import diag_frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic   clk = 1'b0;
    logic   resetn = 1'b0;
    logic   dpv1_mode = 1'b0;
    logic   diag_int_enable = 1'b0;
    logic   ext_wr_en = 1'b0;
    logic   int_ack = 1'b0;
    logic   rd_req, rd_valid, diag_int, int_incoming;
    logic   [4:0] cond = 5'h00;
    event_t diag_events = 8'h00;
    len_t   req_len = 6'h20;
    len_t   frame_len;
    addr_t  ext_wr_addr = 5'h00;
    addr_t  rd_addr;
    byte_t  ext_wr_data = 8'h00;
    byte_t  rd_data, station_state_byte_first, got;
    byte_t  bit_exp [5] = '{8'h02, 8'h04, 8'h10, 8'h40, 8'h80};
    int     err_total = 0;
    int     samples_checked = 0;
    int     cycles = 0;
    int     i;

    fieldbus_slave_diag_status dut (
        .clk, .resetn, .dpv1_mode, .diag_int_enable, .diag_events,
        .starting_up(cond[0]), .cfg_mismatch(cond[1]),
        .unsupported_req(cond[2]), .type_mismatch(cond[3]),
        .foreign_master(cond[4]), .req_len, .ext_wr_en,
        .ext_wr_addr, .ext_wr_data, .rd_req, .rd_addr, .int_ack,
        .rd_valid, .rd_data, .frame_len, .station_state_byte_first,
        .diag_int, .int_incoming);
    dp_master_model mst (.clk, .rd_valid, .rd_data, .rd_req, .rd_addr);

    // ****
    // Helpers
    // ****
    initial forever #4 clk = ~clk;
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input byte_t g, input byte_t e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input addr_t a, input byte_t e);
        mst.read(a, got);
        chk(got, e);
    endtask
    task automatic wr(input addr_t a, input byte_t d);
        @(posedge clk);
        ext_wr_en   <= 1'b1;
        ext_wr_addr <= a;
        ext_wr_data <= d;
        @(posedge clk);
        ext_wr_en   <= 1'b0;
    endtask
    task automatic ack();
        @(posedge clk);
        int_ack <= 1'b1;
        @(posedge clk);
        int_ack <= 1'b0;
        tick(1);
    endtask

    // ****
    // Tests
    // ****
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        tick(1);
        chk({2'h0, frame_len}, 8'h20);
        chk(station_state_byte_first, 8'h00);
        chk({6'h00, diag_int, int_incoming}, 8'h00);
        done("reset");
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            cond <= 5'(1 << i);
            tick(2);
            chk(station_state_byte_first, bit_exp[i]);
        end
        rd(5'h00, 8'h80);
        @(posedge clk);
        cond <= 5'h1f;
        rd(5'h00, 8'hd6);
        @(posedge clk);
        cond <= 5'h00;
        rd(5'h00, 8'h00);
        rd(5'h01, 8'h04);
        done("status");
        wr(5'h05, 8'ha5);
        wr(5'h01, 8'hff);
        wr(5'h1f, 8'h3c);
        rd(5'h05, 8'ha5);
        rd(5'h01, 8'h04);
        @(posedge clk);
        req_len <= 6'h1f;
        tick(2);
        chk({2'h0, frame_len}, 8'h1f);
        rd(5'h1f, 8'h00);
        @(posedge clk);
        req_len <= 6'h28;
        tick(2);
        chk({2'h0, frame_len}, 8'h20);
        rd(5'h1f, 8'h3c);
        done("frame");
        @(posedge clk);
        diag_int_enable <= 1'b1;
        diag_events     <= 8'h01;
        tick(2);
        chk({7'h00, diag_int}, 8'h00);
        @(posedge clk);
        dpv1_mode       <= 1'b1;
        diag_int_enable <= 1'b0;
        diag_events     <= 8'h00;
        tick(2);
        chk({7'h00, diag_int}, 8'h00);
        @(posedge clk);
        diag_int_enable <= 1'b1;
        diag_events     <= 8'h04;
        tick(2);
        chk({6'h00, diag_int, int_incoming}, 8'h03);
        chk(station_state_byte_first, 8'h08);
        ack();
        chk({6'h00, diag_int, int_incoming}, 8'h01);
        @(posedge clk);
        diag_events <= 8'h00;
        tick(2);
        chk({6'h00, diag_int, int_incoming}, 8'h02);
        chk(station_state_byte_first, 8'h00);
        ack();
        chk({7'h00, diag_int}, 8'h00);
        done("interrupt");
        close_out();
    end
endmodule
